// file: hw/sixirq_pkg.sv
/*
 * Constants for the six-source interrupt gating block: enable register
 * bit map, register offsets of the plain register port, reset values,
 * machine-cycle state numbers and vector indices.
 * Assumes a single 100 MHz clock with a synchronous active-low reset.
 */
package sixirq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_SRC = 6;
    // Register offsets.
    localparam logic [3:0] OFS_ENABLE_MASK = 4'h0;
    localparam logic [3:0] OFS_T2_CONTROL = 4'h1;
    localparam logic [3:0] OFS_MODE = 4'h2;
    localparam logic [3:0] OFS_EVT_STATUS = 4'h3;
    localparam logic [3:0] OFS_EVT_CLEAR = 4'h4;
    localparam logic [3:0] OFS_EVT_ENABLE = 4'h5;
    localparam logic [3:0] OFS_PENDING = 4'h6;
    // Enable register bit positions.
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_TIMER2 = 5;
    localparam int BIT_SERIAL = 4;
    localparam int BIT_TIMER1 = 3;
    localparam int BIT_EXT1 = 2;
    localparam int BIT_TIMER0 = 1;
    localparam int BIT_EXT0 = 0;
    // Timer 2 control register flag positions.
    localparam int BIT_T2_OVF = 7;
    localparam int BIT_T2_EXT = 6;
    // Mode register bit positions.
    localparam int BIT_MODE_UPDOWN = 0;
    localparam int BIT_MODE_BAUD = 1;
    localparam int BIT_MODE_IDLE = 2;
    // Reset values.
    localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
    localparam logic [7:0] RST_T2_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_EVT = 8'h00;
    // Machine-cycle states: six states of two phases each.
    localparam logic [2:0] STATE_T2_SET = 3'h2;
    localparam logic [2:0] STATE_T01_SET = 3'h5;
    localparam logic [2:0] STATE_LAST = 3'h6;
    localparam logic [2:0] STATE_FIRST = 3'h1;
    // Polling-order vector indices.
    localparam logic [2:0] VEC_EXT0 = 3'h0;
    localparam logic [2:0] VEC_TIMER0 = 3'h1;
    localparam logic [2:0] VEC_EXT1 = 3'h2;
    localparam logic [2:0] VEC_TIMER1 = 3'h3;
    localparam logic [2:0] VEC_SERIAL = 3'h4;
    localparam logic [2:0] VEC_TIMER2 = 3'h5;
    localparam logic [2:0] VEC_NONE = 3'h7;
    // Event status bits.
    localparam int EVT_VECTOR = 0;
    localparam int EVT_WAKE = 1;
    localparam int EVT_T2_OVF = 2;
    localparam int EVT_T2_EXT = 3;
endpackage

// file: hw/sixirq_gating.sv
/*
 * Interrupt request gating for six sources with per-source and global
 * enables, timer 2 request flags, machine-cycle timed flag setting and
 * polling, fixed-priority vector selection and idle wake-up.
 * Assumes pins extIrqPin0/1 are asynchronous and all other inputs come
 * from logic on clk; the CPU core acknowledges a request with vecAck.
 */
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sixirq_gating
    import sixirq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    input wire logic extIrqPin0,
    input wire logic extIrqPin1,
    input wire logic timer0Overflow,
    input wire logic timer1Overflow,
    input wire logic timer2Rollover,
    input wire logic timer2ExtEvent,
    input wire logic serialIrq,
    input wire logic vecAck,
    output logic irqValid,
    output logic [2:0] irqVector,
    output logic cpuIdle,
    output logic evtIrq
);
    logic [DATA_W-1:0] enableMask_ff, nxt_enableMask;
    logic [DATA_W-1:0] t2Control_ff, nxt_t2Control;
    logic [DATA_W-1:0] mode_ff, nxt_mode;
    logic [DATA_W-1:0] evtStatus_ff, nxt_evtStatus;
    logic [DATA_W-1:0] evtEnable_ff, nxt_evtEnable;
    logic [DATA_W-1:0] regRdata_ff, nxt_regRdata;
    logic [1:0] pin0Sync_ff, pin1Sync_ff;
    logic t0Flag_ff, nxt_t0Flag, t1Flag_ff, nxt_t1Flag;
    logic t0Ovf_ff, nxt_t0Ovf, t1Ovf_ff, nxt_t1Ovf;
    logic t2Ovf_ff, nxt_t2Ovf;
    logic [2:0] state_ff, nxt_state;
    logic phase_ff, nxt_phase;
    logic [NUM_SRC-1:0] polled_ff, nxt_polled;
    logic [2:0] vector_ff, nxt_vector;
    logic valid_ff, nxt_valid;
    logic [NUM_SRC-1:0] rawReq, gatedReq;
    logic t2Request, cycleEnd;

    // Picks the first pending source in polling order.
    function automatic logic [2:0] pickVector(input logic [NUM_SRC-1:0] req);
        logic [2:0] v;
        v = VEC_NONE;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                v = 3'(i);
            end
        end
        return v;
    endfunction

    // Writes a register when the strobe hits its offset.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs,
        input logic wr);
        return wr && (a == ADDR_W'(ofs));
    endfunction

    // Marks the second phase of a given machine-cycle state.
    function automatic logic atSlot(input logic [2:0] st, input logic ph,
        input logic [2:0] want);
        return ph && (st == want);
    endfunction

    // Two-stage synchronisers for the asynchronous request pins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // The pins idle high, so the stages start high and no false request follows reset.
            pin0Sync_ff <= 2'h3;
            pin1Sync_ff <= 2'h3;
        end else if (clkEn) begin
            pin0Sync_ff <= {pin0Sync_ff[0], extIrqPin0};
            pin1Sync_ff <= {pin1Sync_ff[0], extIrqPin1};
        end
    end

    assign cycleEnd = atSlot(state_ff, phase_ff, STATE_LAST);

    // Machine-cycle sequencer: states one to six, two phases each.
    always_comb begin
        nxt_phase = ~phase_ff;
        nxt_state = state_ff;
        if (phase_ff) begin
            nxt_state = cycleEnd ? STATE_FIRST : state_ff + 3'h1;
        end
    end

    // Reset starts the sequence at state one, first phase.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= STATE_FIRST;
            phase_ff <= 1'b0;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
        end
    end

    // Timer flag staging and request formation.
    always_comb begin
        nxt_t0Ovf = t0Ovf_ff | timer0Overflow;
        nxt_t1Ovf = t1Ovf_ff | timer1Overflow;
        nxt_t0Flag = t0Flag_ff;
        nxt_t1Flag = t1Flag_ff;
        nxt_t2Ovf = t2Ovf_ff | (timer2Rollover && !mode_ff[BIT_MODE_BAUD]);
        nxt_t2Control = t2Control_ff;
        // An acknowledge clears the old flag first, so that an overflow set
        // in the same cycle is not lost.
        if (vecAck && vector_ff == VEC_TIMER0) begin
            nxt_t0Flag = 1'b0;
        end
        if (vecAck && vector_ff == VEC_TIMER1) begin
            nxt_t1Flag = 1'b0;
        end
        if (atSlot(state_ff, phase_ff, STATE_T01_SET)) begin
            nxt_t0Flag = nxt_t0Flag | t0Ovf_ff;
            nxt_t1Flag = nxt_t1Flag | t1Ovf_ff;
            nxt_t0Ovf = timer0Overflow;
            nxt_t1Ovf = timer1Overflow;
        end
        if (hit(regAddr, OFS_T2_CONTROL, regWr)) begin
            nxt_t2Control = regWdata;
        end
        // Hardware sets of the timer 2 flags follow the software write, so they win.
        if (atSlot(state_ff, phase_ff, STATE_T2_SET) && t2Ovf_ff) begin
            nxt_t2Control[BIT_T2_OVF] = 1'b1;
            nxt_t2Ovf = timer2Rollover && !mode_ff[BIT_MODE_BAUD];
        end
        if (timer2ExtEvent) begin
            nxt_t2Control[BIT_T2_EXT] = 1'b1;
        end
    end

    // Timer 2 flags are cleared only by software writes, never by vecAck.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            t0Flag_ff <= 1'b0;
            t1Flag_ff <= 1'b0;
            t0Ovf_ff <= 1'b0;
            t1Ovf_ff <= 1'b0;
            t2Ovf_ff <= 1'b0;
            t2Control_ff <= RST_T2_CONTROL;
        end else if (clkEn) begin
            t0Flag_ff <= nxt_t0Flag;
            t1Flag_ff <= nxt_t1Flag;
            t0Ovf_ff <= nxt_t0Ovf;
            t1Ovf_ff <= nxt_t1Ovf;
            t2Ovf_ff <= nxt_t2Ovf;
            t2Control_ff <= nxt_t2Control;
        end
    end

    // Raw requests per vector slot, then the per-source and global gates.
    always_comb begin
        t2Request = t2Control_ff[BIT_T2_OVF]
            | (t2Control_ff[BIT_T2_EXT] && !mode_ff[BIT_MODE_UPDOWN]);
        rawReq = '0;
        rawReq[VEC_EXT0] = ~pin0Sync_ff[1];
        rawReq[VEC_TIMER0] = t0Flag_ff;
        rawReq[VEC_EXT1] = ~pin1Sync_ff[1];
        rawReq[VEC_TIMER1] = t1Flag_ff;
        rawReq[VEC_SERIAL] = serialIrq;
        rawReq[VEC_TIMER2] = t2Request;
        gatedReq[VEC_EXT0] = rawReq[VEC_EXT0] & enableMask_ff[BIT_EXT0];
        gatedReq[VEC_TIMER0] = rawReq[VEC_TIMER0] & enableMask_ff[BIT_TIMER0];
        gatedReq[VEC_EXT1] = rawReq[VEC_EXT1] & enableMask_ff[BIT_EXT1];
        gatedReq[VEC_TIMER1] = rawReq[VEC_TIMER1] & enableMask_ff[BIT_TIMER1];
        gatedReq[VEC_SERIAL] = rawReq[VEC_SERIAL] & enableMask_ff[BIT_SERIAL];
        gatedReq[VEC_TIMER2] = rawReq[VEC_TIMER2] & enableMask_ff[BIT_TIMER2];
        if (!enableMask_ff[BIT_GLOBAL]) begin
            gatedReq = '0;
        end
    end

    // Polling once per machine cycle; a new vector is offered at cycle end.
    always_comb begin
        nxt_polled = polled_ff;
        nxt_vector = vector_ff;
        nxt_valid = valid_ff;
        if (atSlot(state_ff, phase_ff, STATE_T2_SET)) begin
            nxt_polled = gatedReq;
            // The timer 2 overflow reaches its flag on this same edge; polling it
            // here keeps it inside the machine cycle of the overflow.
            nxt_polled[VEC_TIMER2] = gatedReq[VEC_TIMER2] | (t2Ovf_ff
                && enableMask_ff[BIT_GLOBAL] && enableMask_ff[BIT_TIMER2]);
        end
        if (vecAck) begin
            nxt_valid = 1'b0;
        end
        if (cycleEnd && !valid_ff) begin
            nxt_vector = pickVector(polled_ff & gatedReq);
            nxt_valid = |(polled_ff & gatedReq);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            polled_ff <= '0;
            vector_ff <= VEC_NONE;
            valid_ff <= 1'b0;
        end else if (clkEn) begin
            polled_ff <= nxt_polled;
            vector_ff <= nxt_vector;
            valid_ff <= nxt_valid;
        end
    end

    // Register file and event status.
    always_comb begin
        nxt_enableMask = enableMask_ff;
        nxt_mode = mode_ff;
        nxt_evtEnable = evtEnable_ff;
        nxt_evtStatus = evtStatus_ff;
        nxt_regRdata = '0;
        if (hit(regAddr, OFS_ENABLE_MASK, regWr)) begin
            nxt_enableMask = regWdata;
            nxt_enableMask[BIT_RESERVED] = 1'b0;
        end
        if (hit(regAddr, OFS_MODE, regWr)) begin
            nxt_mode = regWdata;
        end
        if (hit(regAddr, OFS_EVT_ENABLE, regWr)) begin
            nxt_evtEnable = regWdata;
        end
        if (hit(regAddr, OFS_EVT_CLEAR, regWr)) begin
            nxt_evtStatus = evtStatus_ff & ~regWdata;
        end
        // Event sets follow the clear, so that a set in the same cycle wins.
        // Idle mode is entered by software and left on any enabled request.
        if (mode_ff[BIT_MODE_IDLE] && |gatedReq) begin
            nxt_mode[BIT_MODE_IDLE] = 1'b0;
            nxt_evtStatus[EVT_WAKE] = 1'b1;
        end
        if (cycleEnd && !valid_ff && |(polled_ff & gatedReq)) begin
            nxt_evtStatus[EVT_VECTOR] = 1'b1;
        end
        if (atSlot(state_ff, phase_ff, STATE_T2_SET) && t2Ovf_ff) begin
            nxt_evtStatus[EVT_T2_OVF] = 1'b1;
        end
        if (timer2ExtEvent) begin
            nxt_evtStatus[EVT_T2_EXT] = 1'b1;
        end
        // Read data goes to zero after each enabled cycle without a read strobe, and holds while clkEn is low.
        if (regRd) begin
            unique case (regAddr)
                OFS_ENABLE_MASK: nxt_regRdata = enableMask_ff;
                OFS_T2_CONTROL: nxt_regRdata = t2Control_ff;
                OFS_MODE: nxt_regRdata = mode_ff;
                OFS_EVT_STATUS: nxt_regRdata = evtStatus_ff;
                OFS_EVT_ENABLE: nxt_regRdata = evtEnable_ff;
                OFS_PENDING: nxt_regRdata = {2'h0, rawReq};
                default: nxt_regRdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enableMask_ff <= RST_ENABLE_MASK;
            mode_ff <= RST_MODE;
            evtEnable_ff <= RST_EVT;
            evtStatus_ff <= RST_EVT;
            regRdata_ff <= '0;
        end else if (clkEn) begin
            enableMask_ff <= nxt_enableMask;
            mode_ff <= nxt_mode;
            evtEnable_ff <= nxt_evtEnable;
            evtStatus_ff <= nxt_evtStatus;
            regRdata_ff <= nxt_regRdata;
        end
    end

    assign regRdata = regRdata_ff;
    assign irqValid = valid_ff;
    assign irqVector = vector_ff;
    assign cpuIdle = mode_ff[BIT_MODE_IDLE];
    // The event interrupt is a level, high while any enabled status bit is set.
    assign evtIrq = |(evtStatus_ff & evtEnable_ff);
endmodule // sixirq_gating

// file: verif/sixirq_chk.sv
/* Port checker for the six-source interrupt gating block.
   Assumes it is bound to sixirq_gating with clkEn normally high. */
`timescale 1ns/1ps
module sixirq_chk
    import sixirq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic timer0Overflow,
    input wire logic vecAck,
    input wire logic irqValid,
    input wire logic [2:0] irqVector,
    input wire logic cpuIdle
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (clkEn && !regRd |=> regRdata == 8'h00)
        else $error("read data outside read slot");
    a_bit6_zero: assert property (
        clkEn && regRd && regAddr == OFS_ENABLE_MASK |=> !regRdata[BIT_RESERVED])
        else $error("reserved enable bit reads one");
    a_unmapped_zero: assert property (
        clkEn && regRd && regAddr > OFS_PENDING |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_vec_legal: assert property (irqValid |-> irqVector <= VEC_TIMER2)
        else $error("offered vector out of range");
    a_offer_holds: assert property (
        irqValid && !vecAck |=> irqValid && $stable(irqVector))
        else $error("offer dropped before acknowledge");
    a_idle_wake: assert property (cpuIdle && irqValid |-> ##[0:13] !cpuIdle)
        else $error("enabled request left idle set");
    a_idle_sw_only: assert property (
        !cpuIdle && !(regWr && regAddr == OFS_MODE) |=> !cpuIdle)
        else $error("idle entered without a mode write");
    a_t0_not_early: assert property (
        timer0Overflow && !irqValid |=> (!(irqValid && irqVector == VEC_TIMER0))[*8])
        else $error("timer 0 offered before its flag cycle");
endmodule // sixirq_chk

bind sixirq_gating sixirq_chk i_chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timer0Overflow(timer0Overflow), .vecAck(vecAck), .irqValid(irqValid),
    .irqVector(irqVector), .cpuIdle(cpuIdle));

// file: verif/sixirq_cpu_model.sv
/* Core model that takes an offered vector after a set number of cycles.
   Assumes irqValid stands until the one-cycle acknowledge is seen. */
`timescale 1ns/1ps
module sixirq_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irqValid,
    input wire logic [3:0] ackDelay,
    output logic vecAck
);
    logic [3:0] waitCnt_ff;
    // The acknowledge takes the vector and clears a timer 0 or 1 flag; timer 2 flags stay for software.
    always_ff @(posedge clk) begin
        if (!rst_n || !irqValid || vecAck) begin
            waitCnt_ff <= 4'h0;
            vecAck <= 1'b0;
        end else begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
            vecAck <= (waitCnt_ff == ackDelay);
        end
    end
endmodule // sixirq_cpu_model

// file: verif/six_source_interrupt_gating_test.sv
/* Self-checking bench for sixirq_gating with a core acknowledge model.
   Assumes the package, design, checker and model are compiled first. */
`timescale 1ns/1ps
module six_source_interrupt_gating_test
    import sixirq_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [3:0] regAddr = 4'h0, ackDelay = 4'h0;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic pin0 = 1'b1, pin1 = 1'b1, tov0 = 1'b0, tov1 = 1'b0, tov2 = 1'b0;
    logic t2ev = 1'b0, ser = 1'b0, vecAck, irqValid, cpuIdle, evtIrq;
    logic [2:0] irqVector;
    int failCount = 0, samplesChecked = 0;

    sixirq_gating i_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .extIrqPin0(pin0), .extIrqPin1(pin1), .timer0Overflow(tov0),
        .timer1Overflow(tov1), .timer2Rollover(tov2), .timer2ExtEvent(t2ev),
        .serialIrq(ser), .vecAck(vecAck), .irqValid(irqValid), .irqVector(irqVector),
        .cpuIdle(cpuIdle), .evtIrq(evtIrq));
    sixirq_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .irqValid(irqValid),
        .ackDelay(ackDelay), .vecAck(vecAck));

    always #5 clk = ~clk;

    task automatic check(input string nm, input logic [7:0] seen, exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check(nm, regRdata, exp);
    endtask
    task automatic fire(input int i, input logic lvl);
        case (i)
            0: pin0 <= !lvl;
            1: tov0 <= lvl;
            2: pin1 <= !lvl;
            3: tov1 <= lvl;
            4: ser <= lvl;
            5: tov2 <= lvl;
            default: t2ev <= lvl;
        endcase
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        fire(i, 1'b1);
        @(posedge clk);
        fire(i, 1'b0);
    endtask
    task automatic waitFor(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (n < 60 && irqValid !== lvl);
        check("offer level", {7'h00, irqValid}, {7'h00, lvl});
    endtask
    task automatic quiet(input string nm);
        logic seen;
        seen = 1'b0;
        repeat (36) begin
            @(posedge clk);
            #1 seen = seen | irqValid;
        end
        check(nm, {7'h00, seen}, 8'h00);
    endtask

    task automatic tRegs();
        rdc(OFS_ENABLE_MASK, RST_ENABLE_MASK, "mask reset");
        rdc(OFS_T2_CONTROL, RST_T2_CONTROL, "t2 control reset");
        wr(OFS_ENABLE_MASK, 8'hBF);
        wr(4'hF, 8'h5A);
        rdc(OFS_ENABLE_MASK, 8'hBF, "mask bit map");
        rdc(4'hF, 8'h00, "unmapped");
        @(posedge clk);
        regAddr <= OFS_ENABLE_MASK;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        clkEn <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check("frozen read", regRdata, 8'hBF);
        @(posedge clk);
        clkEn <= 1'b1;
        @(posedge clk);
        #1 check("thawed read", regRdata, 8'h00);
        wr(OFS_ENABLE_MASK, 8'h00);
    endtask
    task automatic tEach();
        int n;
        for (int i = 0; i < NUM_SRC; i++) begin
            wr(OFS_ENABLE_MASK, 8'h80 | (8'h01 << i));
            if (i % 2 == 0 && i < 5) begin
                @(posedge clk);
                fire(i, 1'b1);
            end else pulse(i);
            waitFor(1'b1, n);
            check("vector", {5'h00, irqVector}, i[7:0]);
            if (i == 1 || i == 3) check("t01 delay", {7'h00, n > 12}, 8'h01);
            if (i == 5) check("t2 delay", {7'h00, n < 25}, 8'h01);
            wr(OFS_ENABLE_MASK, 8'h00);
            fire(i, 1'b0);
            waitFor(1'b0, n);
        end
        rdc(OFS_T2_CONTROL, 8'h80, "t2 flag kept");
        wr(OFS_T2_CONTROL, 8'h00);
        rdc(OFS_PENDING, 8'h00, "flags after ack");
    endtask
    task automatic tGlobal();
        int n;
        ackDelay <= 4'h5;
        wr(OFS_ENABLE_MASK, 8'h3F);
        pulse(1);
        quiet("global off");
        rdc(OFS_PENDING, 8'h02, "raw pending");
        wr(OFS_ENABLE_MASK, 8'hBD);
        quiet("source off");
        wr(OFS_ENABLE_MASK, 8'h82);
        waitFor(1'b1, n);
        check("late enable", {5'h00, irqVector}, {5'h00, VEC_TIMER0});
        waitFor(1'b0, n);
        ackDelay <= 4'h0;
    endtask
    task automatic tTimer2();
        int n;
        wr(OFS_ENABLE_MASK, 8'hA0);
        wr(OFS_MODE, 8'h01);
        pulse(6);
        quiet("updown ext flag");
        wr(OFS_T2_CONTROL, 8'h00);
        wr(OFS_MODE, 8'h02);
        pulse(5);
        quiet("baud rollover");
        rdc(OFS_T2_CONTROL, 8'h00, "baud no flag");
        wr(OFS_MODE, 8'h00);
        pulse(6);
        waitFor(1'b1, n);
        check("ext flag vector", {5'h00, irqVector}, {5'h00, VEC_TIMER2});
        wr(OFS_ENABLE_MASK, 8'h00);
        rdc(OFS_T2_CONTROL, 8'h40, "ext flag kept");
        wr(OFS_T2_CONTROL, 8'h00);
        waitFor(1'b0, n);
    endtask
    task automatic tOrder();
        int n;
        @(posedge clk);
        fire(4, 1'b1);
        pulse(3);
        repeat (24) @(posedge clk);
        wr(OFS_ENABLE_MASK, 8'h98);
        waitFor(1'b1, n);
        check("first", {5'h00, irqVector}, {5'h00, VEC_TIMER1});
        waitFor(1'b0, n);
        waitFor(1'b1, n);
        check("second", {5'h00, irqVector}, {5'h00, VEC_SERIAL});
        wr(OFS_ENABLE_MASK, 8'h00);
        fire(4, 1'b0);
        waitFor(1'b0, n);
    endtask
    task automatic tIdle();
        int n;
        wr(OFS_EVT_CLEAR, 8'h0F);
        wr(OFS_MODE, 8'h04);
        #1 check("idle set", {7'h00, cpuIdle}, 8'h01);
        wr(OFS_ENABLE_MASK, 8'h81);
        @(posedge clk);
        fire(0, 1'b1);
        waitFor(1'b1, n);
        repeat (13) @(posedge clk);
        #1 check("idle wake", {7'h00, cpuIdle}, 8'h00);
        wr(OFS_ENABLE_MASK, 8'h00);
        fire(0, 1'b0);
        waitFor(1'b0, n);
        rdc(OFS_EVT_STATUS, 8'h03, "event status");
        check("event masked", {7'h00, evtIrq}, 8'h00);
        wr(OFS_EVT_ENABLE, 8'h02);
        #1 check("event raised", {7'h00, evtIrq}, 8'h01);
        wr(OFS_EVT_CLEAR, 8'h02);
        #1 check("event cleared", {7'h00, evtIrq}, 8'h00);
        rdc(OFS_EVT_STATUS, 8'h01, "status after clear");
    endtask

    task automatic finalReport();
        $display("checks %0d failures %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        finalReport();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        tRegs();
        tEach();
        tGlobal();
        tTimer2();
        tOrder();
        tIdle();
        finalReport();
    end
endmodule // six_source_interrupt_gating_test
